//--- design/twp_pkg.sv
// Shared constants and carrier types for the transmit partition write port
package twp_pkg;
   localparam int unsigned TWP_NUM_PART = 8;
   localparam int unsigned TWP_PART_W = 3;
   localparam int unsigned TWP_LINES_PER_PART = 8;
   localparam int unsigned TWP_LINE_IDX_W = 3;
   localparam int unsigned TWP_PTR_W = 4;
   localparam int unsigned TWP_NUM_LINES = 64;
   localparam int unsigned TWP_LINE_WORDS = 4;
   localparam logic [1:0] TWP_LAST_WORD = 2'h3;
   localparam logic [3:0] TWP_PART_CAP = 4'h8;
   localparam logic [3:0] TWP_FILL_LEVEL_RST = 4'h6;
   localparam logic [3:0] TWP_BE_NONE = 4'h0;

   // Write port pins as seen on the fabric side
   typedef struct packed {
      logic wclk;
      logic strobe;
      logic sop;
      logic eop;
      logic err;
      logic term;
      logic [3:0] be;
      logic [7:0] port;
      logic [2:0] sel;
      logic [31:0] data;
   } twp_wr_in_type;

   // One 128-bit buffer line with its marks
   typedef struct packed {
      logic [3:0][31:0] data;
      logic [2:0] words;
      logic [3:0] last_be;
      logic [7:0] port;
      logic sop;
      logic eop;
      logic err;
   } twp_line_type;

   // Line handed to the link side
   typedef struct packed {
      logic valid;
      logic [2:0] part;
      twp_line_type line;
   } twp_link_out_type;

   localparam twp_wr_in_type TWP_WR_IN_RST = '0;
   localparam twp_line_type TWP_LINE_RST = '0;
   localparam twp_link_out_type TWP_LINK_OUT_RST = '0;
endpackage

//--- design/twp_tx_partition_write_port.sv
// Transmit partition write port: buffer RAM, partition pointers, full flag, drain arbiter
`timescale 1ns/10ps

module twp_tx_partition_write_port
   import twp_pkg::*;
(
   // Core clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Fabric write port
   input wire logic tx_write_clock,
   input wire logic tx_write_strobe,
   input wire logic tx_pkt_start_mark,
   input wire logic tx_pkt_end_mark,
   input wire logic tx_pkt_error_mark,
   input wire logic tx_line_terminate,
   input wire logic [3:0] tx_byte_valid_mask,
   input wire logic [7:0] tx_logical_port_num,
   input wire logic [2:0] tx_partition_select,
   input wire logic [31:0] tx_write_word,
   input wire logic tx_buffer_drain_disable,
   output logic tx_partition_full_flag,
   // Configuration
   input wire logic [3:0] cfg_fill_level,
   // Link side
   input wire logic link_ready,
   output twp_link_out_type link_line,
   output logic link_idle
);

   typedef struct packed {
      logic [2:0] clk_sync;
      twp_wr_in_type in_s0;
      twp_wr_in_type in_s1;
      twp_wr_in_type in_s2;
      logic [1:0] dis_sync;
      logic [TWP_NUM_PART-1:0][TWP_PTR_W-1:0] wr_ptr;
      logic [TWP_NUM_PART-1:0][TWP_PTR_W-1:0] rd_ptr;
      logic [TWP_NUM_PART-1:0][1:0] word_idx;
      logic [TWP_PART_W-1:0] rr_ptr;
      logic full;
      twp_link_out_type out;
      logic idle;
      twp_line_type [TWP_NUM_LINES-1:0] ram;
   } twp_state_type;

   twp_state_type state_ff;
   twp_state_type nxt_state;

   function automatic logic [TWP_PTR_W-1:0] occ(input logic [TWP_PTR_W-1:0] wp,
                                                 input logic [TWP_PTR_W-1:0] rp);
      occ = wp - rp;
   endfunction

   always_comb begin
      twp_wr_in_type w;
      logic wedge;
      logic [TWP_PART_W-1:0] p;
      logic [TWP_PART_W+TWP_LINE_IDX_W-1:0] li;
      logic [1:0] wi;
      logic room;
      logic adv;
      logic found;
      logic [TWP_PART_W-1:0] q;
      logic [TWP_PART_W+TWP_LINE_IDX_W-1:0] ri;
      w = state_ff.in_s2;
      wedge = 1'b0;
      p = '0;
      li = '0;
      wi = '0;
      room = 1'b0;
      adv = 1'b0;
      found = 1'b0;
      q = '0;
      ri = '0;
      nxt_state = state_ff;

      // Sample pins through two flops; one extra stage holds data from before the edge
      nxt_state.clk_sync = {state_ff.clk_sync[1:0], tx_write_clock};
      nxt_state.in_s0 = '{wclk: tx_write_clock, strobe: tx_write_strobe,
                          sop: tx_pkt_start_mark, eop: tx_pkt_end_mark,
                          err: tx_pkt_error_mark, term: tx_line_terminate,
                          be: tx_byte_valid_mask, port: tx_logical_port_num,
                          sel: tx_partition_select, data: tx_write_word};
      nxt_state.in_s1 = state_ff.in_s0;
      nxt_state.in_s2 = state_ff.in_s1;
      nxt_state.dis_sync = {state_ff.dis_sync[0], tx_buffer_drain_disable};
      wedge = state_ff.clk_sync[1] & ~state_ff.clk_sync[2];

      // Write side, accepted whether or not draining is disabled
      if (wedge) begin
         p = w.sel;
         li = {p, state_ff.wr_ptr[p][TWP_LINE_IDX_W-1:0]};
         wi = state_ff.word_idx[p];
         room = occ(state_ff.wr_ptr[p], state_ff.rd_ptr[p]) != TWP_PART_CAP;
         if (w.strobe && w.be != TWP_BE_NONE && room) begin
            if (wi == 2'h0) begin
               nxt_state.ram[li] = TWP_LINE_RST;
               nxt_state.ram[li].sop = w.sop;
               nxt_state.ram[li].port = w.port;
            end
            nxt_state.ram[li].data[wi] = w.data;
            nxt_state.ram[li].words = {1'b0, wi} + 3'h1;
            nxt_state.ram[li].last_be = w.be;
            nxt_state.ram[li].eop = w.eop;
            nxt_state.ram[li].err = w.err & w.eop;
            if (w.eop || wi == TWP_LAST_WORD) begin
               adv = 1'b1;
            end else begin
               nxt_state.word_idx[p] = wi + 2'h1;
            end
         end
         if (w.term && room && wi != 2'h0) begin
            adv = 1'b1;
         end
         if (adv) begin
            // Pointer wraps inside the partition through its low bits
            nxt_state.wr_ptr[p] = state_ff.wr_ptr[p] + 4'h1;
            nxt_state.word_idx[p] = 2'h0;
         end
         // Full flag for the partition now selected
         nxt_state.full = occ(nxt_state.wr_ptr[w.sel], state_ff.rd_ptr[w.sel])
                          > cfg_fill_level;
      end

      // Drain arbiter: round robin over partitions holding complete lines
      // Whole link word returns to zero in every cycle without a line
      nxt_state.out = TWP_LINK_OUT_RST;
      nxt_state.idle = 1'b1;
      if (link_ready && !state_ff.dis_sync[1]) begin
         for (int i = 0; i < TWP_NUM_PART; i++) begin
            q = state_ff.rr_ptr + i[TWP_PART_W-1:0];
            if (!found && occ(state_ff.wr_ptr[q], state_ff.rd_ptr[q]) != 4'h0) begin
               found = 1'b1;
               ri = {q, state_ff.rd_ptr[q][TWP_LINE_IDX_W-1:0]};
               nxt_state.out.valid = 1'b1;
               nxt_state.out.part = q;
               nxt_state.out.line = state_ff.ram[ri];
               nxt_state.idle = 1'b0;
               nxt_state.rd_ptr[q] = state_ff.rd_ptr[q] + 4'h1;
               nxt_state.rr_ptr = q + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= '0;
         state_ff.idle <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign tx_partition_full_flag = state_ff.full;
   assign link_line = state_ff.out;
   assign link_idle = state_ff.idle;

endmodule

//--- testbench/twp_tx_partition_write_port_sva.sv
// Checker for the transmit partition write port
`timescale 1ns/10ps
module twp_tx_partition_write_port_sva
   import twp_pkg::*;
(
   input wire logic clock, rst_n, tx_write_clock, tx_buffer_drain_disable,
   input wire logic tx_partition_full_flag, link_ready, link_idle,
   input wire logic [3:0] cfg_fill_level,
   input wire twp_link_out_type link_line
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_idle; link_line.valid |-> !link_idle; endproperty
   a_idle: assert property (p_idle) else $error("idle high with line out");
   property p_stop; tx_buffer_drain_disable [*5] |-> !link_line.valid; endproperty
   a_stop: assert property (p_stop) else $error("line out while disabled");
   property p_zero; tx_buffer_drain_disable [*5] |-> link_idle && link_line == '0; endproperty
   a_zero: assert property (p_zero) else $error("link not idle while disabled");
   property p_ready; link_line.valid |-> $past(link_ready); endproperty
   a_ready: assert property (p_ready) else $error("line out without request");
   property p_err; link_line.valid && link_line.line.err |-> link_line.line.eop; endproperty
   a_err: assert property (p_err) else $error("error mark without end mark");
   property p_words; link_line.valid |-> link_line.line.words inside {[3'h1:3'h4]}; endproperty
   a_words: assert property (p_words) else $error("bad word count");
   property p_full; tx_partition_full_flag |-> cfg_fill_level < 4'h8; endproperty
   a_full: assert property (p_full) else $error("full above capacity");
   property p_hold; !$rose(tx_write_clock) [*7] |=> $stable(tx_partition_full_flag); endproperty
   a_hold: assert property (p_hold) else $error("full moved off write edge");
   c_line: cover property (link_line.valid);
   c_full: cover property ($rose(tx_partition_full_flag));
   c_eop: cover property (link_line.valid && link_line.line.eop);
endmodule
bind twp_tx_partition_write_port twp_tx_partition_write_port_sva twp_sva_i (.clock, .rst_n,
   .tx_write_clock, .tx_buffer_drain_disable, .tx_partition_full_flag, .link_ready,
   .link_idle, .cfg_fill_level, .link_line);

//--- testbench/twp_wr_model.sv
// Fabric writer model on its own write clock
`timescale 1ns/10ps
module twp_wr_model
   import twp_pkg::*;
(
   // Write port pins
   output twp_wr_in_type wr
);
   initial begin
      wr = TWP_WR_IN_RST;
      #7;
      forever #24 wr.wclk = ~wr.wclk;
   end
   // Flags are sop, eop, err, terminate
   task automatic put(input logic [2:0] sel, input logic [3:0] be, input logic [31:0] d,
      input logic [3:0] f);
      @(negedge wr.wclk);
      wr.strobe <= ~f[0];
      wr.term <= f[0];
      wr.sop <= f[3];
      wr.eop <= f[2];
      wr.err <= f[1] & f[2];
      wr.be <= be;
      wr.sel <= sel;
      wr.port <= {5'h15, sel};
      wr.data <= d;
   endtask
   task automatic rel;
      @(negedge wr.wclk);
      wr.strobe <= 1'b0;
      wr.term <= 1'b0;
      wr.data <= ~wr.data;
   endtask
endmodule

//--- testbench/twp_tx_partition_write_port_test.sv
// Self-checking bench for the transmit partition write port
`timescale 1ns/10ps
module twp_tx_partition_write_port_test import twp_pkg::*;;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic dis = 1'b1;
   logic rdy = 1'b1;
   logic [3:0] lvl = 4'h2;
   logic full, idle;
   twp_wr_in_type wr;
   twp_link_out_type lo;
   twp_link_out_type q[$];
   int n_fail = 0;
   int n_tests = 0;
   always #2 clock = ~clock;
   twp_wr_model twp_wr_model_i (.wr(wr));
   twp_tx_partition_write_port twp_tx_partition_write_port_i (.clock(clock), .rst_n(rst_n),
      .tx_write_clock(wr.wclk), .tx_write_strobe(wr.strobe), .tx_pkt_start_mark(wr.sop),
      .tx_pkt_end_mark(wr.eop), .tx_pkt_error_mark(wr.err), .tx_line_terminate(wr.term),
      .tx_byte_valid_mask(wr.be), .tx_logical_port_num(wr.port),
      .tx_partition_select(wr.sel), .tx_write_word(wr.data), .tx_buffer_drain_disable(dis),
      .tx_partition_full_flag(full), .cfg_fill_level(lvl), .link_ready(rdy),
      .link_line(lo), .link_idle(idle));
   always @(posedge clock) if (lo.valid === 1'b1) q.push_back(lo);
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("BAD %s exp %h got %h", nm, exp, got);
         n_fail++;
      end
   endtask
   task automatic fill_disabled;
      for (int i = 0; i < 3; i++)
         for (int k = 0; k < 4; k++)
            twp_wr_model_i.put(3'h2, 4'hf, {24'h5a0000, 4'(i), 4'(k)}, {k == 0, 3'h0});
      twp_wr_model_i.put(3'h2, 4'hf, 32'h5a000030, 4'h8);
      twp_wr_model_i.put(3'h2, 4'he, 32'h5a000031, 4'h6);
      twp_wr_model_i.put(3'h2, 4'hf, 32'h5a000040, 4'h8);
      twp_wr_model_i.put(3'h2, 4'hf, 32'h0, 4'h1);
      twp_wr_model_i.rel();
      repeat (8) @(posedge clock);
      chk("full_sel2", 1, full);
      chk("held", 0, 32'(q.size()));
      twp_wr_model_i.put(3'h3, 4'h0, 32'h5a0000ff, 4'hc);
      twp_wr_model_i.rel();
      repeat (8) @(posedge clock);
      chk("full_sel3", 0, full);
   endtask
   task automatic drain_check;
      logic [2:0] wc [5] = '{3'h4, 3'h4, 3'h4, 3'h2, 3'h1};
      dis <= 1'b0;
      repeat (30) @(posedge clock);
      chk("lines", 5, 32'(q.size()));
      for (int i = 0; i < q.size() && i < 5; i++) begin
         chk("part", 2, q[i].part);
         chk("words", wc[i], q[i].line.words);
         chk("word0", {24'h5a0000, 4'(i), 4'h0}, q[i].line.data[0]);
         chk("port", 8'haa, q[i].line.port);
         chk("sop", 1, q[i].line.sop);
      end
      chk("eop_err", 2'h3, {q[3].line.eop, q[3].line.err});
      chk("last_be", 4'he, q[3].line.last_be);
      chk("idle", 1, idle);
   endtask
   task automatic complete_run;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #20000;
      n_fail++;
      complete_run();
   end
   initial begin
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      repeat (4) @(posedge clock);
      fill_disabled();
      @(posedge clock);
      drain_check();
      complete_run();
   end
endmodule
